// ==== hdl/iswb_pkg.sv ====
// Purpose: Shared constants and carrier types of the I2C mailbox bridge.
// Assumes: One 50 MHz system clock.
// Notes: Buffer sizes and section lengths are fixed by the host protocol.
package iswb_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h71;
  localparam int RX_DEPTH = 202;
  localparam int TX_DEPTH = 12;
  localparam int CRC_BYTES = 2;
  localparam int STATIC_LEN = 7;
  localparam int CONT_LEN = 120;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam int CLK_MHZ = 50;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam int PWR_ON_BIT = 0;

  // Bus events from the slave engine, all one-cycle pulses except rd and rx_data
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_edge;
    logic addr_hit;
    logic rd;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_req;
    logic nack;
  } iswb_evt_t;
endpackage

// ==== hdl/iswb_crc16.sv ====
// Purpose: Byte-wide CRC-16 accumulator.
// Assumes: One byte per enabled cycle, MSB first.
// Notes: Clear and enable together restart the sum with that byte.
`timescale 1ns/10ps
module iswb_crc16 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [15:0] seed;

  // Eight serial steps folded into one cycle
  function automatic logic [15:0] iswb_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ iswb_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next value
  always_comb begin
    seed = clr ? iswb_pkg::CRC_INIT : crc_r;
    crc_nxt = en ? iswb_crc_step(seed, din) : seed;
  end

  // Register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_r <= iswb_pkg::CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;
endmodule

// ==== hdl/iswb_i2c_slave.sv ====
// Purpose: Byte level I2C slave engine with address filter.
// Assumes: scl_in and sda_in already synchronous to clk.
// Notes: SDA is open drain; the engine only ever pulls low.
`timescale 1ns/10ps
module iswb_i2c_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  input wire logic abort,
  input wire logic wr_allow,
  input wire logic [7:0] tx_data,
  output iswb_pkg::iswb_evt_t evt
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_WR = 7'h08,
    S_WACK = 7'h10,
    S_RD = 7'h20,
    S_RACK = 7'h40
  } iswb_sst_t;

  iswb_sst_t st_r, st_nxt;
  logic scl_r, sda_r, oe_r, oe_nxt, rd_r, rd_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rise, fall, start, stop;

  assign rise = scl_in & ~scl_r;
  assign fall = ~scl_in & scl_r;
  assign start = scl_in & scl_r & sda_r & ~sda_in;
  assign stop = scl_in & scl_r & ~sda_r & sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // Bit sequencing; SDA changes only on SCL falling edges, except the release on abort, stop or start
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    oe_nxt = oe_r;
    rd_nxt = rd_r;
    evt = '0;
    evt.start = start;
    evt.stop = stop;
    evt.scl_edge = rise | fall;
    evt.rd = rd_r;
    evt.rx_data = sh_r;
    if (abort || stop) begin
      st_nxt = S_IDLE;
      oe_nxt = 1'b0;
    end else if (start) begin
      st_nxt = S_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        S_ADDR: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h8) begin
            if (sh_r[7:1] == iswb_pkg::SLAVE_ADDR) begin
              st_nxt = S_AACK;
              oe_nxt = 1'b1;
              rd_nxt = sh_r[0];
              evt.addr_hit = 1'b1;
              evt.rd = sh_r[0];
            end else begin
              st_nxt = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (fall) begin
            cnt_nxt = 4'h0;
            if (rd_r) begin
              sh_nxt = tx_data;
              oe_nxt = ~tx_data[7];
              evt.tx_req = 1'b1;
              st_nxt = S_RD;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = S_WR;
            end
          end
        end
        S_WR: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h8) begin
            // No room means NACK, so the host sees the loss
            evt.rx_valid = wr_allow;
            evt.nack = ~wr_allow;
            oe_nxt = wr_allow;
            st_nxt = S_WACK;
          end
        end
        S_WACK: begin
          if (fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            st_nxt = S_WR;
          end
        end
        S_RD: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == 4'h8) begin
              oe_nxt = 1'b0;
              st_nxt = S_RACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b1};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            sh_nxt = {7'h00, sda_in};
          end else if (fall) begin
            if (!sh_r[0]) begin
              sh_nxt = tx_data;
              oe_nxt = ~tx_data[7];
              evt.tx_req = 1'b1;
              cnt_nxt = 4'h0;
              st_nxt = S_RD;
            end else begin
              st_nxt = S_IDLE;
            end
          end
        end
        S_IDLE: begin
          oe_nxt = 1'b0;
        end
        default: begin
          st_nxt = S_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      rd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      scl_r <= scl_in;
      sda_r <= sda_in;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      oe_r <= oe_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign sda_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_addr_filter: assert property (
    (st_r == S_ADDR && fall && !start && !stop && !abort && cnt_r == 4'h8
      && sh_r[7:1] != iswb_pkg::SLAVE_ADDR) |=> (st_r == S_IDLE && !oe_r))
    else $error("foreign address was not ignored");

  a_hit_ack: assert property (
    evt.addr_hit |=> (oe_r && st_r == S_AACK))
    else $error("address hit without ACK drive");
endmodule

// ==== hdl/iswb_bridge.sv ====
// Purpose: I2C slave mailbox bridging a host master to a wireless link.
// Assumes: I2C pins synchronous to clk; wireless side is byte streams.
// Notes: Notifications have no back-pressure; the sink must keep up.
//
// How it works
// - Answer only slave address 0x71.
// - Store host write bytes in 202-byte buffer.
// - Return 12-byte send buffer on reads.
// - Start plus address hit raises transfer event.
// - Check integrity only after clean completion.
// - Two trailing CRC-16 bytes checked on each clean write transfer.
// - Rewind buffer pointers after each transfer.
// - Load phone command plus fresh CRC.
// - Split into 7 static, 120 continuous bytes.
// - Forward sections only after good write.
// - Notify without waiting for acknowledgement.
// - Power-on request reaches send buffer.
// - Indicator shows data arrived from phone.
// - Start idle, slave reception enabled.
`timescale 1ns/10ps
module iswb_bridge #(
  parameter int RX_DEPTH = iswb_pkg::RX_DEPTH,
  parameter int TX_DEPTH = iswb_pkg::TX_DEPTH,
  parameter int TIMEOUT_CYC = iswb_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic ntf_valid,
  output logic [7:0] ntf_data,
  output logic ntf_static,
  output logic ntf_last,
  output logic motor_en,
  output logic led_out,
  output logic err_flag,
  input wire logic err_clr
);
  localparam int RAW = $clog2(RX_DEPTH + 1);
  localparam int TAW = $clog2(TX_DEPTH + 1);
  localparam int TOW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [RAW-1:0] RX_FULL = RAW'(RX_DEPTH);
  localparam logic [RAW-1:0] STATIC_LAST = RAW'(iswb_pkg::STATIC_LEN - 1);
  localparam logic [RAW-1:0] STATIC_END = RAW'(iswb_pkg::STATIC_LEN);
  localparam logic [RAW-1:0] SPLIT_LAST =
    RAW'(iswb_pkg::STATIC_LEN + iswb_pkg::CONT_LEN - 1);
  localparam logic [RAW-1:0] MIN_LEN =
    RAW'(iswb_pkg::STATIC_LEN + iswb_pkg::CONT_LEN + iswb_pkg::CRC_BYTES);
  localparam logic [TAW-1:0] CMD_MAX = TAW'(TX_DEPTH - iswb_pkg::CRC_BYTES);
  localparam logic [TAW-1:0] TX_END = TAW'(TX_DEPTH);
  localparam logic [TOW-1:0] TO_LAST = TOW'(TIMEOUT_CYC - 1);

  typedef enum logic [6:0] {
    T_IDLE = 7'h01,
    T_XFER = 7'h02,
    T_CHECK = 7'h04,
    T_SPLIT = 7'h08,
    T_CMD = 7'h10,
    T_CRCHI = 7'h20,
    T_CRCLO = 7'h40
  } iswb_tst_t;

  iswb_tst_t st_r, st_nxt;
  logic wr_r, wr_nxt, nack_r, nack_nxt;
  logic [RAW-1:0] rx_ptr_r, rx_ptr_nxt, rx_len_r, rx_len_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [TAW-1:0] tx_ptr_r, tx_ptr_nxt, cmd_ptr_r, cmd_ptr_nxt;
  logic [TOW-1:0] to_cnt_r, to_nxt;
  logic motor_r, motor_nxt, led_r, led_nxt, err_r, err_nxt, err_set;
  logic nv_r, nv_nxt, ns_r, ns_nxt, nl_r, nl_nxt;
  logic [7:0] nd_r, nd_nxt;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [7:0] tx_mem [TX_DEPTH];
  logic rx_we, tx_we, abort, wr_allow, crc_clr, crc_en;
  logic [TAW-1:0] tx_waddr;
  logic [7:0] tx_wdata, tx_byte, crc_din;
  logic [15:0] crc_val;
  iswb_pkg::iswb_evt_t evt;

  ////////////////////////////////////////////////////////////////////////////
  // Slave engine and checksum unit
  iswb_i2c_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .abort(abort),
    .wr_allow(wr_allow),
    .tx_data(tx_byte),
    .evt(evt)
  );

  iswb_crc16 u_crc (
    .clk(clk),
    .rst_n(rst_n),
    .clr(crc_clr),
    .en(crc_en),
    .din(crc_din),
    .crc(crc_val)
  );

  // Writes are taken only in a live write with room left
  assign wr_allow = (st_r == T_XFER) && wr_r && (rx_ptr_r != RX_FULL);
  // Reads past the end return filler rather than wrapping
  assign tx_byte = (tx_ptr_r < TX_END) ? tx_mem[tx_ptr_r] : iswb_pkg::IDLE_BYTE;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Control sequencing
  always_comb begin
    st_nxt = st_r;
    wr_nxt = wr_r;
    nack_nxt = nack_r;
    rx_ptr_nxt = rx_ptr_r;
    rx_len_nxt = rx_len_r;
    tx_ptr_nxt = tx_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cmd_ptr_nxt = cmd_ptr_r;
    to_nxt = '0;
    motor_nxt = motor_r;
    led_nxt = led_r;
    err_set = 1'b0;
    nv_nxt = 1'b0;
    nd_nxt = nd_r;
    ns_nxt = ns_r;
    nl_nxt = 1'b0;
    abort = 1'b0;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_din = cmd_data;
    rx_we = 1'b0;
    tx_we = 1'b0;
    tx_waddr = cmd_ptr_r;
    tx_wdata = cmd_data;
    cmd_ready = 1'b0;
    // Read pointer runs in any state; a stop always rewinds it
    if (evt.tx_req && tx_ptr_r != TX_END) begin
      tx_ptr_nxt = tx_ptr_r + 1'b1;
    end
    if (evt.stop) begin
      tx_ptr_nxt = '0;
    end
    case (st_r)
      T_IDLE: begin
        crc_clr = 1'b1;
        if (evt.addr_hit) begin
          st_nxt = T_XFER;
          wr_nxt = ~evt.rd;
          nack_nxt = 1'b0;
          rx_ptr_nxt = '0;
        end else begin
          cmd_ready = 1'b1;
        end
      end
      T_XFER: begin
        if (evt.rx_valid) begin
          rx_we = 1'b1;
          rx_ptr_nxt = rx_ptr_r + 1'b1;
        end
        if (evt.nack) begin
          nack_nxt = 1'b1;
        end
        if (!evt.scl_edge) begin
          to_nxt = to_cnt_r + 1'b1;
        end
        if (to_cnt_r == TO_LAST) begin
          abort = 1'b1;
          err_set = 1'b1;
          st_nxt = T_IDLE;
          rx_ptr_nxt = '0;
          tx_ptr_nxt = '0;
        end else if (evt.stop || evt.start) begin
          rx_ptr_nxt = '0;
          tx_ptr_nxt = '0;
          rx_len_nxt = rx_ptr_r;
          rd_ptr_nxt = '0;
          crc_clr = 1'b1;
          st_nxt = (wr_r && !nack_r && rx_ptr_r != '0) ? T_CHECK : T_IDLE;
        end
      end
      T_CHECK: begin
        // Sum runs over payload and trailer; a clean block leaves zero
        if (rd_ptr_r != rx_len_r) begin
          crc_en = 1'b1;
          crc_din = rx_mem[rd_ptr_r];
          rd_ptr_nxt = rd_ptr_r + 1'b1;
        end else begin
          rd_ptr_nxt = '0;
          if (crc_val == 16'h0000 && rx_len_r >= MIN_LEN) begin
            st_nxt = T_SPLIT;
          end else begin
            err_set = 1'b1;
            st_nxt = T_IDLE;
          end
        end
      end
      T_SPLIT: begin
        // One byte per cycle, no stall input on purpose
        nv_nxt = 1'b1;
        nd_nxt = rx_mem[rd_ptr_r];
        ns_nxt = rd_ptr_r < STATIC_END;
        nl_nxt = (rd_ptr_r == STATIC_LAST) || (rd_ptr_r == SPLIT_LAST);
        rd_ptr_nxt = rd_ptr_r + 1'b1;
        if (rd_ptr_r == SPLIT_LAST) begin
          st_nxt = T_IDLE;
        end
      end
      T_CMD: begin
        cmd_ready = 1'b1;
      end
      T_CRCHI: begin
        tx_we = 1'b1;
        tx_wdata = crc_val[15:8];
        cmd_ptr_nxt = cmd_ptr_r + 1'b1;
        st_nxt = T_CRCLO;
      end
      T_CRCLO: begin
        tx_we = 1'b1;
        tx_wdata = crc_val[7:0];
        cmd_ptr_nxt = '0;
        led_nxt = ~led_r;
        st_nxt = T_IDLE;
      end
      default: begin
        st_nxt = T_IDLE;
      end
    endcase
    // Command bytes; overflow past the payload room is dropped
    if (cmd_ready && cmd_valid) begin
      if (cmd_ptr_r == '0) begin
        motor_nxt = cmd_data[iswb_pkg::PWR_ON_BIT];
      end
      if (cmd_ptr_r != CMD_MAX) begin
        tx_we = 1'b1;
        crc_en = 1'b1;
        cmd_ptr_nxt = cmd_ptr_r + 1'b1;
      end
      st_nxt = cmd_last ? T_CRCHI : T_CMD;
    end
    // Set wins over a simultaneous clear
    err_nxt = err_set | (err_r & ~err_clr);
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= T_IDLE;
      wr_r <= 1'b0;
      nack_r <= 1'b0;
      rx_ptr_r <= '0;
      rx_len_r <= '0;
      tx_ptr_r <= '0;
      rd_ptr_r <= '0;
      cmd_ptr_r <= '0;
      to_cnt_r <= '0;
      motor_r <= 1'b0;
      led_r <= 1'b0;
      err_r <= 1'b0;
      nv_r <= 1'b0;
      nd_r <= 8'h00;
      ns_r <= 1'b0;
      nl_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      wr_r <= wr_nxt;
      nack_r <= nack_nxt;
      rx_ptr_r <= rx_ptr_nxt;
      rx_len_r <= rx_len_nxt;
      tx_ptr_r <= tx_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cmd_ptr_r <= cmd_ptr_nxt;
      to_cnt_r <= to_nxt;
      motor_r <= motor_nxt;
      led_r <= led_nxt;
      err_r <= err_nxt;
      nv_r <= nv_nxt;
      nd_r <= nd_nxt;
      ns_r <= ns_nxt;
      nl_r <= nl_nxt;
    end
  end

  // Buffer storage; contents survive pointer rewinds
  always_ff @(posedge clk) begin
    if (rx_we) begin
      rx_mem[rx_ptr_r] <= evt.rx_data;
    end
    if (tx_we) begin
      tx_mem[tx_waddr] <= tx_wdata;
    end
  end

  assign ntf_valid = nv_r;
  assign ntf_data = nd_r;
  assign ntf_static = ns_r;
  assign ntf_last = nl_r;
  assign motor_en = motor_r;
  assign led_out = led_r;
  assign err_flag = err_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_static_run;
    (nv_r && ns_r) [*7];
  endsequence

  sequence s_cont_start;
    nv_r && !ns_r;
  endsequence

  a_rx_store: assert property (
    (st_r == T_XFER && evt.rx_valid && to_cnt_r != TO_LAST) |=>
      rx_ptr_r == $past(rx_ptr_r) + 1'b1)
    else $error("receive pointer did not advance");

  a_ptr_rewind: assert property (
    (st_r == T_XFER && evt.stop) |=> (rx_ptr_r == '0 && tx_ptr_r == '0))
    else $error("pointers not rewound after transfer");

  a_nack_gate: assert property (
    (st_r == T_XFER && evt.stop && nack_r) |=> st_r == T_IDLE)
    else $error("nacked transfer went to checking");

  a_crc_reject: assert property (
    (st_r == T_CHECK && rd_ptr_r == rx_len_r && crc_val != 16'h0000) |=>
      (err_r && st_r == T_IDLE))
    else $error("bad checksum not flagged");

  a_split_sections: assert property (
    (st_r == T_CHECK && st_nxt == T_SPLIT) |=> ##1 s_static_run ##1 s_cont_start)
    else $error("static section length wrong");

  a_notify_source: assert property (
    nv_r |-> $past(st_r) == T_SPLIT)
    else $error("notification outside a validated split");

  a_no_stall: assert property (
    (st_r == T_SPLIT && rd_ptr_r < SPLIT_LAST) |=> (st_r == T_SPLIT && nv_r))
    else $error("split stalled");

  a_cmd_crc: assert property (
    (st_r == T_CRCHI) |=> (st_r == T_CRCLO) ##1 (st_r == T_IDLE))
    else $error("checksum append sequence broken");

  a_led_toggle: assert property (
    (st_r == T_CRCLO) |=> led_r != $past(led_r))
    else $error("indicator did not mark arrival");

  a_power_on: assert property (
    (cmd_ready && cmd_valid && cmd_ptr_r == '0) |=>
      motor_r == $past(cmd_data[iswb_pkg::PWR_ON_BIT]))
    else $error("power request not decoded");

  a_timeout: assert property (
    (st_r == T_XFER && to_cnt_r == TO_LAST) |=> (err_r && st_r == T_IDLE))
    else $error("timeout not handled");
endmodule

// ==== verif/iswb_i2c_master.sv ====
// Purpose: Behavioural I2C master that stands in for the host controller.
// Assumes: SDA resolved by the bench with a pull-up; SCL low or high for 4 clocks.
// Notes: Slow on purpose so every bit straddles several system clocks.
`timescale 1ns/10ps
module iswb_i2c_master (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Idle bus at time zero so the device sees SCL and SDA high at release
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Data changes only while SCL is low, two clocks clear of each edge
  task automatic put_bit(input logic b);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  // Released line reads the pull-up, never the last driven value
  task automatic get_bit(output logic b);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    b = sda;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic start_c();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask

  // Host writes its data, then reads the send buffer back
  task automatic wr_byte(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(nak);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) get_bit(b[i]);
    put_bit(nack);
  endtask
endmodule

// ==== verif/iswb_bridge_bench.sv ====
// Purpose: Self-checking bench of the I2C mailbox bridge.
// Assumes: Timeout shortened to 50 clocks; far side is the master model.
// Notes: Payloads and commands come from a fixed-seed xorshift.
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, 16'(e), 16'(g))
module iswb_bridge_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, sda, nak;
  logic cmd_valid = 1'b0;
  logic cmd_last = 1'b0;
  logic err_clr = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, ntf_valid, ntf_static, ntf_last, motor_en, led_out, err_flag;
  logic [7:0] ntf_data, rb;
  logic [7:0] pay [0:202];
  logic [7:0] cmd [0:3];
  logic [15:0] c;
  logic [31:0] seed = 32'h5F1616EF;
  int n_errors = 0;
  int tests_run = 0;
  int n_ntf = 0;

  always #10 clk = ~clk;
  // Open drain: low when either party pulls, pull-up otherwise
  assign sda = ~(sda_low | sda_oe);

  iswb_bridge #(.TIMEOUT_CYC(50)) i_iswb_bridge (.clk(clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready), .ntf_valid(ntf_valid),
    .ntf_data(ntf_data), .ntf_static(ntf_static), .ntf_last(ntf_last), .motor_en(motor_en),
    .led_out(led_out), .err_flag(err_flag), .err_clr(err_clr));
  iswb_i2c_master i_iswb_i2c_master (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // MSB-first CRC-16, one byte per call
  function automatic logic [15:0] crc_step(logic [15:0] s, logic [7:0] b);
    s = s ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) s = s[15] ? ((s << 1) ^ iswb_pkg::CRC_POLY) : (s << 1);
    return s;
  endfunction

  task automatic check(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_write(input int n);
    i_iswb_i2c_master.start_c();
    i_iswb_i2c_master.wr_byte({iswb_pkg::SLAVE_ADDR, 1'b0}, nak);
    `CHK("addr_ack", 0, nak);
    for (int i = 0; i < n; i++) begin
      i_iswb_i2c_master.wr_byte(pay[i], nak);
      `CHK("data_ack", i >= iswb_pkg::RX_DEPTH, nak);
    end
    i_iswb_i2c_master.stop_c();
  endtask

  // One beat per rising edge with ready high; the beat stands until that edge
  task automatic send_cmd(input int k);
    int w;
    for (int i = 0; i < k; i++) begin
      cmd_valid <= 1'b1;
      cmd_data <= cmd[i];
      cmd_last <= (i == k - 1);
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (cmd_ready !== 1'b1 && w < 100);
      `CHK("cmd_ready", 1, cmd_ready);
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
  endtask

  // Every notification beat is checked against the last good payload
  always @(posedge clk) begin
    if (rst_n && ntf_valid === 1'b1) begin
      `CHK("ntf_data", pay[n_ntf], ntf_data);
      `CHK("ntf_static", n_ntf < iswb_pkg::STATIC_LEN, ntf_static);
      `CHK("ntf_last", n_ntf == 6 || n_ntf == 126, ntf_last);
      n_ntf++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("idle_oe", 0, sda_oe);
    `CHK("sda_out", 0, sda_out);
    `CHK("idle_ready", 1, cmd_ready);
    `CHK("idle_out", 0, {motor_en, led_out, err_flag, ntf_valid});
    // Foreign address must be left unanswered
    rb = xs();
    if (rb[6:0] == iswb_pkg::SLAVE_ADDR) rb = 8'h70;
    i_iswb_i2c_master.start_c();
    i_iswb_i2c_master.wr_byte({rb[6:0], 1'b0}, nak);
    `CHK("foreign_nak", 1, nak);
    i_iswb_i2c_master.stop_c();
    // Good write: 127 payload bytes plus big-endian trailer
    c = iswb_pkg::CRC_INIT;
    for (int i = 0; i < 127; i++) begin
      pay[i] = xs();
      c = crc_step(c, pay[i]);
    end
    pay[127] = c[15:8];
    pay[128] = c[7:0];
    do_write(129);
    for (int i = 0; i < 3000 && n_ntf < 127; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK("ntf_count", 127, n_ntf);
    `CHK("err_good", 0, err_flag);
    // Corrupted trailer: flagged and never forwarded
    pay[128] = pay[128] ^ 8'h01;
    do_write(129);
    repeat (600) @(posedge clk);
    `CHK("err_crc", 1, err_flag);
    `CHK("ntf_blocked", 127, n_ntf);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("err_cleared", 0, err_flag);
    // Overlong write: the byte past the buffer is NACKed, so nothing is checked
    for (int i = 129; i <= iswb_pkg::RX_DEPTH; i++) pay[i] = xs();
    do_write(iswb_pkg::RX_DEPTH + 1);
    repeat (600) @(posedge clk);
    `CHK("err_nacked", 0, err_flag);
    `CHK("ntf_nacked", 127, n_ntf);
    // Commands of 1 and 3 bytes, each read back twice
    for (int r = 0; r < 2; r++) begin
      k = 1 + 2 * r;
      c = iswb_pkg::CRC_INIT;
      for (int i = 0; i < k; i++) begin
        cmd[i] = xs();
        if (i == 0) cmd[i][iswb_pkg::PWR_ON_BIT] = (r == 0);
        c = crc_step(c, cmd[i]);
      end
      send_cmd(k);
      repeat (4) @(posedge clk);
      `CHK("motor_en", r == 0, motor_en);
      `CHK("led_out", r == 0, led_out);
      for (int n = 0; n < 2; n++) begin
        i_iswb_i2c_master.start_c();
        i_iswb_i2c_master.wr_byte({iswb_pkg::SLAVE_ADDR, 1'b1}, nak);
        `CHK("rd_ack", 0, nak);
        for (int i = 0; i < k + 2; i++) begin
          i_iswb_i2c_master.rd_byte(i == k + 1, rb);
          `CHK("rd_data", i < k ? cmd[i] : (i == k ? c[15:8] : c[7:0]), rb);
        end
        i_iswb_i2c_master.stop_c();
      end
    end
    // Master stalls with SCL low past the timeout
    i_iswb_i2c_master.start_c();
    i_iswb_i2c_master.wr_byte({iswb_pkg::SLAVE_ADDR, 1'b0}, nak);
    repeat (60) @(posedge clk);
    `CHK("err_timeout", 1, err_flag);
    i_iswb_i2c_master.stop_c();
    close_out();
  end

  // Hang guard well past the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
